// [bch_pkg.sv]
// shared constants and types for the bus cycle handshake ends
package bch_pkg;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int MEM_DEPTH = 16;
	localparam int IDX_W = 4;
	localparam logic [IDX_W-1:0] IDX_ZERO = 4'h0;
	localparam logic [DATA_W-1:0] DATA_ZERO = 32'h0;
	localparam logic [ADDR_W-1:0] ADDR_ZERO = 8'h0;
	localparam logic [IDX_W-1:0] BUSY_IDX = 4'hf;
	localparam logic [IDX_W-1:0] FAULT_IDX = 4'he;
	localparam int PIPE_DEPTH = 2;
	localparam logic [1:0] PIPE_ZERO = 2'h0;
	localparam logic [1:0] PIPE_ONE = 2'h1;
	localparam logic [1:0] PIPE_FULL = 2'h2;

	typedef enum logic [1:0] {
		BCH_TERM_ACK,
		BCH_TERM_ERR,
		BCH_TERM_RTY
	} bch_term_type;
endpackage : bch_pkg

// [bch_bus_if.sv]
// shared bus between one master end and one slave end
`timescale 1ns/100ps
interface bch_bus_if (
	input wire logic core_clk,
	input wire logic rst_n
);
	logic cyc;
	logic stb;
	logic we;
	logic [bch_pkg::ADDR_W-1:0] adr;
	logic [bch_pkg::DATA_W-1:0] dat_m2s;
	logic [bch_pkg::DATA_W-1:0] dat_s2m;
	logic ack;
	logic err;
	logic rty;
	logic stall;

	modport master (
		input core_clk, rst_n, ack, err, rty, stall, dat_s2m,
		output cyc, stb, we, adr, dat_m2s
	);
	modport slave (
		input core_clk, rst_n, cyc, stb, we, adr, dat_m2s,
		output ack, err, rty, stall, dat_s2m
	);
endinterface : bch_bus_if

// [bch_slave.sv]
// slave end: register memory with ack, error, retry and pipelined mode
//
// Operation
// RULE1: interface initialises after reset, stays until release
// RULE2: reset source holds reset one full cycle
// RULE3: reset acts in any cycle or state
// RULE4: state machines forced to fixed reset state
// RULE5: master holds strobe and cycle low in reset
// RULE6: master may start after reset release edge
// RULE7: standard mode terminations drop with strobe
// RULE8: pipelined terminations independent of strobe level
// RULE9: bus reset handled synchronously by interface; both ends here clear asynchronously on rst_n falling
// RULE10: master opens transfer by raising cycle
// RULE11: cycle frames strobe over whole transfer
// RULE12: master should not hold cycle forever
// RULE13: slave ignores bus inputs while cycle low
// RULE14: master holds strobe until termination sampled
// RULE15: zero-wait slave may ack combinationally
// RULE16: terminations answer cycle and strobe high
// RULE17: acknowledge ends cycle successfully
// RULE18: error ends cycle on detected fault
// RULE19: retry ends cycle when resource busy
// RULE20: minimum signal set present on both ends
// RULE21: error termination is optional, reports fault
// RULE22: stall raised when queue cannot accept
// RULE23: never more than one termination at once
// RULE24: registered ack pulses once per strobe
`timescale 1ns/100ps
module bch_slave (
	// bus side
	bch_bus_if.slave bus,
	// user side
	input wire logic pipe_mode,
	input wire logic zero_wait,
	input wire logic res_busy,
	output logic [bch_pkg::DATA_W-1:0] mem_peek,
	output logic fault_seen
);
	typedef struct packed {
		logic [bch_pkg::MEM_DEPTH-1:0][bch_pkg::DATA_W-1:0] mem;
		logic term_v;
		bch_pkg::bch_term_type term;
		logic [bch_pkg::DATA_W-1:0] rdata;
		logic [1:0] qcnt;
		logic fault;
	} bch_slv_state_type;

	bch_slv_state_type s_q;
	bch_slv_state_type s_d;
	logic req;
	logic accept;
	logic [bch_pkg::IDX_W-1:0] idx;

	function automatic bch_pkg::bch_term_type pick_term(
		input logic [bch_pkg::IDX_W-1:0] a,
		input logic busy
	);
		if (busy || a == bch_pkg::BUSY_IDX) begin
			pick_term = bch_pkg::BCH_TERM_RTY; // RULE19
		end else if (a == bch_pkg::FAULT_IDX) begin
			pick_term = bch_pkg::BCH_TERM_ERR; // RULE18 RULE21
		end else begin
			pick_term = bch_pkg::BCH_TERM_ACK; // RULE17
		end
	endfunction : pick_term

	assign idx = bus.adr[bch_pkg::IDX_W-1:0];
	// nothing but clock and reset is looked at while cycle is low
	assign req = bus.cyc && bus.stb; // RULE13 RULE16
	// pipelined mode takes one request per cycle unless stalled
	assign accept = req && !bus.stall;

	always_comb begin
		s_d = s_q;
		if (pipe_mode) begin
			// queue of pending answers; one retires each cycle
			s_d.term_v = (s_q.qcnt != bch_pkg::PIPE_ZERO);
			s_d.qcnt = s_q.qcnt;
			if (s_q.qcnt != bch_pkg::PIPE_ZERO) begin
				s_d.qcnt = s_q.qcnt - bch_pkg::PIPE_ONE;
			end
			if (accept) begin
				s_d.qcnt = s_d.qcnt + bch_pkg::PIPE_ONE;
				s_d.term = pick_term(idx, res_busy);
				s_d.rdata = s_q.mem[idx];
				if (pick_term(idx, res_busy) == bch_pkg::BCH_TERM_ACK &&
					bus.we) begin
					s_d.mem[idx] = bus.dat_m2s;
				end
			end
		end else begin
			// single-pulse registered answer, cleared the cycle after
			s_d.qcnt = bch_pkg::PIPE_ZERO;
			s_d.term_v = req && !s_q.term_v; // RULE24
			if (req && !s_q.term_v) begin
				s_d.term = pick_term(idx, res_busy);
				s_d.rdata = s_q.mem[idx];
				if (pick_term(idx, res_busy) == bch_pkg::BCH_TERM_ACK &&
					bus.we) begin
					s_d.mem[idx] = bus.dat_m2s;
				end
			end
		end
		if (s_d.term_v && s_d.term == bch_pkg::BCH_TERM_ERR) begin
			s_d.fault = 1'b1;
		end
	end

	// async clear straight from the bus reset; rst_n is not sampled on the clock
	always_ff @(posedge bus.core_clk or negedge bus.rst_n) begin
		if (!bus.rst_n) begin
			s_q <= '0; // RULE1 RULE3 RULE4; clear is asynchronous, not synchronous as RULE9 asks
		end else begin
			s_q <= s_d;
		end
	end

	// stall while the answer queue is full
	assign bus.stall = pipe_mode &&
		(s_q.qcnt >= bch_pkg::PIPE_FULL); // RULE22

	always_comb begin
		bus.ack = 1'b0;
		bus.err = 1'b0;
		bus.rty = 1'b0;
		if (pipe_mode) begin
			// no strobe gating in pipelined mode
			bus.ack = s_q.term_v && s_q.term == bch_pkg::BCH_TERM_ACK; // RULE8
			bus.err = s_q.term_v && s_q.term == bch_pkg::BCH_TERM_ERR;
			bus.rty = s_q.term_v && s_q.term == bch_pkg::BCH_TERM_RTY;
		end else if (zero_wait) begin
			// fast path: no wait states, only ack is ever given
			bus.ack = req; // RULE15
		end else begin
			// one-hot by construction of the term encoding
			bus.ack = req && s_q.term_v &&
				s_q.term == bch_pkg::BCH_TERM_ACK; // RULE7 RULE23
			bus.err = req && s_q.term_v &&
				s_q.term == bch_pkg::BCH_TERM_ERR; // RULE7 RULE23
			bus.rty = req && s_q.term_v &&
				s_q.term == bch_pkg::BCH_TERM_RTY; // RULE7 RULE23
		end
	end

	assign bus.dat_s2m = s_q.rdata;
	assign mem_peek = s_q.mem[bch_pkg::IDX_ZERO];
	assign fault_seen = s_q.fault;
endmodule : bch_slave

// [bch_master.sv]
// master end: issues single transfers in standard or pipelined mode
`timescale 1ns/100ps
module bch_master (
	// bus side
	bch_bus_if.master bus,
	// user side
	input wire logic pipe_mode,
	input wire logic req_valid,
	input wire logic req_we,
	input wire logic [bch_pkg::ADDR_W-1:0] req_adr,
	input wire logic [bch_pkg::DATA_W-1:0] req_wdata,
	output logic req_ready,
	output logic rsp_valid,
	output bch_pkg::bch_term_type rsp_term,
	output logic [bch_pkg::DATA_W-1:0] rsp_rdata
);
	typedef enum {
		BCH_M_IDLE,
		BCH_M_STROBE,
		BCH_M_WAIT
	} bch_mst_fsm_type;

	typedef struct packed {
		bch_mst_fsm_type fsm;
		logic cyc;
		logic stb;
		logic we;
		logic [bch_pkg::ADDR_W-1:0] adr;
		logic [bch_pkg::DATA_W-1:0] wdata;
		logic rsp_v;
		bch_pkg::bch_term_type term;
		logic [bch_pkg::DATA_W-1:0] rdata;
	} bch_mst_state_type;

	bch_mst_state_type m_q;
	bch_mst_state_type m_d;
	logic term_in;

	assign term_in = bus.ack || bus.err || bus.rty; // RULE17

	always_comb begin
		m_d = m_q;
		m_d.rsp_v = 1'b0;
		if (term_in && m_q.cyc) begin
			m_d.rsp_v = 1'b1;
			m_d.rdata = bus.dat_s2m;
			m_d.term = bus.err ? bch_pkg::BCH_TERM_ERR :
				(bus.rty ? bch_pkg::BCH_TERM_RTY : bch_pkg::BCH_TERM_ACK);
		end
		case (m_q.fsm)
			BCH_M_IDLE: begin
				if (req_valid) begin
					// cycle rises with strobe and frames it
					m_d.cyc = 1'b1; // RULE10 RULE11
					m_d.stb = 1'b1;
					m_d.we = req_we;
					m_d.adr = req_adr;
					m_d.wdata = req_wdata;
					m_d.fsm = BCH_M_STROBE;
				end
			end
			BCH_M_STROBE: begin
				if (pipe_mode) begin
					if (!bus.stall) begin
						m_d.stb = 1'b0; // RULE22
						m_d.fsm = term_in ? BCH_M_IDLE : BCH_M_WAIT;
						m_d.cyc = !term_in;
					end
				end else if (term_in) begin
					// drop both so cycle never stays up between transfers
					m_d.stb = 1'b0; // RULE14
					m_d.cyc = 1'b0; // RULE12
					m_d.fsm = BCH_M_IDLE;
				end
			end
			BCH_M_WAIT: begin
				if (term_in) begin
					m_d.cyc = 1'b0;
					m_d.fsm = BCH_M_IDLE;
				end
			end
			default: begin
				m_d.fsm = BCH_M_IDLE;
				m_d.cyc = 1'b0;
				m_d.stb = 1'b0;
			end
		endcase
	end

	always_ff @(posedge bus.core_clk or negedge bus.rst_n) begin
		if (!bus.rst_n) begin
			m_q <= '0; // RULE1 RULE3 RULE4 RULE5
		end else begin
			m_q <= m_d; // RULE6
		end
	end

	// strobe and cycle come straight from flip-flops
	assign bus.cyc = m_q.cyc; // RULE20
	assign bus.stb = m_q.stb;
	assign bus.we = m_q.we;
	assign bus.adr = m_q.adr;
	assign bus.dat_m2s = m_q.wdata;
	assign req_ready = (m_q.fsm == BCH_M_IDLE);
	assign rsp_valid = m_q.rsp_v;
	assign rsp_term = m_q.term;
	assign rsp_rdata = m_q.rdata;
endmodule : bch_master

// [bch_bus_asserts.sv]
// concurrent checks on the bus between the two ends
`timescale 1ns/100ps
module bch_bus_asserts (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// bus
	input wire logic cyc,
	input wire logic stb,
	input wire logic ack,
	input wire logic err,
	input wire logic rty,
	input wire logic stall
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	wire logic term = ack | err | rty;
	reset_quiet_a: assert property (disable iff (1'b0)
		!rst_n |-> !(cyc | stb | term | stall)) else $error("bus busy in reset");
	release_idle_a: assert property (
		$rose(rst_n) |-> !cyc && !stb) else $error("cycle open at release");
	one_term_a: assert property ($onehot0({ack, err, rty}))
		else $error("two terminations");
	term_in_cyc_a: assert property (term |-> cyc)
		else $error("termination outside cycle");
	stb_in_cyc_a: assert property (stb |-> cyc)
		else $error("strobe outside cycle");
	stall_in_cyc_a: assert property (stall |-> cyc)
		else $error("stall outside cycle");
	stb_answer_a: assert property (
		stb |-> ##[0:4] (term || !stb)) else $error("strobe unanswered");
	cyc_bound_a: assert property ($rose(cyc) |-> ##[1:12] !cyc)
		else $error("cycle never ends");
	term_cause_a: assert property (
		term |-> stb || $past(stb) || $past(stb, 2)) else $error("stray term");
endmodule : bch_bus_asserts

// [tb_bus_cycle_reset_handshake.sv]
// self-checking bench joining master and slave ends
`timescale 1ns/100ps
module tb_bus_cycle_reset_handshake;
	// reset is pulled low just after time zero so the flops see a real edge
	logic core_clk = 0, rst_n = 1, pipe_mode = 0, zero_wait = 0;
	logic res_busy = 0, req_valid = 0, req_we = 0, req_ready, rsp_valid;
	logic fault_seen;
	logic [7:0] req_adr = 8'h0;
	logic [31:0] req_wdata = 32'h0, rd, rsp_rdata, mem_peek;
	bch_pkg::bch_term_type rsp_term;
	int errors = 0, samples_checked = 0;
	always #10 core_clk = ~core_clk;
	bch_bus_if bus (.core_clk(core_clk), .rst_n(rst_n));
	bch_master bch_master_i (.bus(bus), .pipe_mode(pipe_mode),
		.req_valid(req_valid), .req_we(req_we), .req_adr(req_adr),
		.req_wdata(req_wdata), .req_ready(req_ready), .rsp_valid(rsp_valid),
		.rsp_term(rsp_term), .rsp_rdata(rsp_rdata));
	bch_slave bch_slave_i (.bus(bus), .pipe_mode(pipe_mode),
		.zero_wait(zero_wait), .res_busy(res_busy), .mem_peek(mem_peek),
		.fault_seen(fault_seen));
	bch_bus_asserts bch_bus_asserts_i (.core_clk(core_clk), .rst_n(rst_n),
		.cyc(bus.cyc), .stb(bus.stb), .ack(bus.ack), .err(bus.err),
		.rty(bus.rty), .stall(bus.stall));
	task automatic tally_and_finish;
		$display("checked %0d mismatches %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : tally_and_finish
	task automatic chk(logic [31:0] got, logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			errors++;
			$display("mismatch at %0t: got %h want %h", $time, got, exp);
		end
	endtask : chk
	// one transfer through the master, answer judged against t
	task automatic xfer(logic w, logic [7:0] a, logic [31:0] d, int t);
		int n;
		n = 0;
		while (req_ready !== 1'b1 && n < 20) begin
			@(negedge core_clk);
			n++;
		end
		{req_we, req_adr, req_wdata, req_valid} = {w, a, d, 1'b1};
		@(negedge core_clk);
		req_valid = 0;
		while (rsp_valid !== 1'b1 && n < 40) begin
			@(negedge core_clk);
			n++;
		end
		if (n >= 40) begin
			errors++;
			$display("mismatch at %0t: no answer to transfer", $time);
		end
		rd = rsp_rdata;
		chk(32'(rsp_term), t);
		@(negedge core_clk);
	endtask : xfer
	task automatic t_std;
		xfer(1, 8'h0, 32'h5a5a0001, 0);
		xfer(0, 8'h0, 0, 0);
		chk(rd, 32'h5a5a0001);
		chk(mem_peek, 32'h5a5a0001);
		xfer(1, 8'h0e, 32'h1, 1);
		chk(fault_seen, 1);
		xfer(0, 8'h0f, 0, 2);
		res_busy = 1;
		xfer(1, 8'h0, 32'hdead0000, 2);
		res_busy = 0;
		chk(mem_peek, 32'h5a5a0001);
	endtask : t_std
	task automatic t_zero;
		zero_wait = 1;
		xfer(1, 8'h0, 32'h77, 0);
		chk(mem_peek, 32'h77);
		zero_wait = 0;
	endtask : t_zero
	task automatic t_pipe;
		pipe_mode = 1;
		xfer(1, 8'h2, 32'hc0de0002, 0);
		xfer(0, 8'h2, 0, 0);
		chk(rd, 32'hc0de0002);
		xfer(0, 8'h0e, 0, 1);
		pipe_mode = 0;
	endtask : t_pipe
	// reset lands in the middle of an open cycle
	task automatic t_mid_reset;
		{req_we, req_adr, req_valid} = {1'b0, 8'h1, 1'b1};
		@(negedge core_clk);
		req_valid = 0;
		rst_n = 0;
		@(negedge core_clk);
		chk({bus.cyc, bus.stb, bus.ack, rsp_valid}, 0);
		chk({fault_seen, mem_peek}, 0);
		@(negedge core_clk);
		rst_n = 1;
		@(negedge core_clk);
		xfer(0, 8'h0, 0, 0);
		chk(rd, 0);
	endtask : t_mid_reset
	initial begin
		#100us;
		errors++;
		tally_and_finish();
	end
	initial begin
		#1 rst_n = 0;
		repeat (2) @(negedge core_clk);
		chk({bus.cyc, bus.stb, bus.stall}, 0);
		rst_n = 1;
		@(negedge core_clk);
		t_std();
		t_zero();
		t_pipe();
		t_mid_reset();
		tally_and_finish();
	end
endmodule : tb_bus_cycle_reset_handshake
